//--- piu_unit.sv
/*
 * Prioritized interrupt unit of an 8-bit core: one non-maskable and four
 * maskable sources, option register, entry and return sequencing with flag sets.
 * Assumes a classic Wishbone master on sys_clk, and a core that pulses insn_end
 * at each instruction boundary and return_from_interrupt on the return instruction.
 */
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps

module piu_unit
    import piu_pkg::*;
#(
    parameter int LDI_CYC = (`PIU_LDI_CYCLES * `PIU_CORE_CYC_NS) / `PIU_CLK_NS,
    parameter int HAZ_CYC = (`PIU_LDI_HAZARD * `PIU_CORE_CYC_NS) / `PIU_CLK_NS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Interrupt sources, active low lines except src2, whose edge polarity is set by the option register; event_in is active high and sets event flags
    input wire logic nmi_b,
    input wire logic src1_b,
    input wire logic src2,
    input wire logic src3_b,
    input wire logic src4_b,
    input wire logic [3:0] event_in,
    // Core handshake
    input wire piu_core_req_s core_i,
    output logic [11:0] pc_load,
    output logic pc_load_en,
    output logic [11:0] stack_data,
    output logic stack_push,
    output logic stack_pop,
    output piu_flags_s flags_in,
    output piu_mode_e mode,
    output logic wake
);

    piu_state_s s_r;
    piu_state_s s_nxt;
    logic gen;
    logic src1_level_select;
    logic src2_edge_polarity;
    logic wr_hit;
    logic req1;
    logic req2;
    logic req3;
    logic req4;
    logic any_mask;
    logic hazard;

    assign gen = s_r.option[`PIU_BIT_GEN];
    assign src1_level_select = s_r.option[`PIU_BIT_LES];
    assign src2_edge_polarity = s_r.option[`PIU_BIT_ESB];
    assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !s_r.ack;

    // Level sources look straight at the line; edge sources look at the latch
    assign req1 = src1_level_select ? !src1_b : s_r.src1_latch;
    assign req2 = s_r.src2_latch;
    assign req3 = !src3_b;
    assign req4 = !src4_b;
    // Enable still counts as set while a clearing write is inside its first cycles
    assign hazard = s_r.wr_cnt > 5'(LDI_CYC - HAZ_CYC);
    assign any_mask = (gen || hazard) && (req1 || req2 || req3 || req4);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.pc_load_en = 1'b0;
        s_nxt.stack_push = 1'b0;
        s_nxt.stack_pop = 1'b0;
        s_nxt.entry_pulse = 1'b0;
        s_nxt.ack = 1'b0;
        s_nxt.src1_prev = src1_b;
        s_nxt.src2_prev = src2;
        // Edge detection: second and later edges collapse into the held latch
        if (!src1_level_select && s_r.src1_prev && !src1_b) begin
            s_nxt.src1_latch = 1'b1;
        end
        if (src2_edge_polarity ? (!s_r.src2_prev && src2) : (s_r.src2_prev && !src2)) begin
            s_nxt.src2_latch = 1'b1;
        end
        if (!nmi_b) begin
            s_nxt.nmi_latch = 1'b1;
        end
        s_nxt.events = s_r.events | event_in;
        // Bus slave; reads of the option register give zero since it is write-only
        if (wb_cyc_i && wb_stb_i && !s_r.ack) begin
            s_nxt.ack = 1'b1;
            s_nxt.dat = 32'h0;
            if (wb_adr_i == `PIU_ADR_EVENTS) begin
                s_nxt.dat = {28'h0, s_r.events};
                if (wb_we_i && wb_sel_i[0]) begin
                    // Write one to clear, a new event wins
                    s_nxt.events = (s_r.events & ~wb_dat_i[3:0]) | event_in;
                end
            end else if (wb_adr_i == `PIU_ADR_STATUS) begin
                s_nxt.dat = {21'h0, s_r.nmi_latch, s_r.src2_latch, s_r.src1_latch, s_r.inhibit,
                    s_r.src_sel, 2'h0, s_r.mode};
            end
        end
        if (wr_hit && wb_adr_i == `PIU_ADR_OPTION) begin
            s_nxt.option = wb_dat_i[7:0];
            // An option write that clears global enable opens the flag-swap hazard
            s_nxt.wr_cnt = (gen && !wb_dat_i[`PIU_BIT_GEN]) ? 5'(LDI_CYC) : 5'h00;
        end else if (s_r.wr_cnt != 5'h00) begin
            s_nxt.wr_cnt = s_r.wr_cnt - 5'h01;
        end
        s_nxt.wake = core_i.sleeping && gen && (s_r.nmi_latch || req1 || req2 || req3 || req4);
        unique case (s_r.state)
            PIU_ST_RUN: begin
                if (core_i.return_from_interrupt && s_r.mode != PIU_MODE_NORMAL) begin
                    s_nxt.stack_pop = 1'b1;
                    s_nxt.mode = s_r.prev_mode;
                    s_nxt.prev_mode = s_r.prev2_mode;
                    s_nxt.prev2_mode = PIU_MODE_NORMAL;
                    s_nxt.inhibit = (s_r.prev_mode != PIU_MODE_NORMAL);
                    unique case (s_r.mode)
                        PIU_MODE_IRQ: s_nxt.flg_irq = core_i.flags_out;
                        PIU_MODE_NMI: s_nxt.flg_nmi = core_i.flags_out;
                        default: s_nxt.flg_normal = core_i.flags_out;
                    endcase
                    unique case (s_r.prev_mode)
                        PIU_MODE_IRQ: s_nxt.flags_in = s_r.flg_irq;
                        PIU_MODE_NMI: s_nxt.flags_in = s_r.flg_nmi;
                        default: s_nxt.flags_in = s_r.flg_normal;
                    endcase
                end else if (core_i.insn_end) begin
                    if (s_r.nmi_latch && s_r.mode != PIU_MODE_NMI) begin
                        s_nxt.src_sel = 3'h0;
                        s_nxt.state = PIU_ST_ENTRY;
                    end else if (any_mask && !s_r.inhibit) begin
                        s_nxt.state = PIU_ST_ENTRY;
                        if (req1) begin
                            s_nxt.src_sel = 3'h1;
                        end else if (req2) begin
                            s_nxt.src_sel = 3'h2;
                        end else if (req3) begin
                            s_nxt.src_sel = 3'h3;
                        end else begin
                            s_nxt.src_sel = 3'h4;
                        end
                    end
                    s_nxt.skip_swap = !s_r.nmi_latch && s_r.mode == PIU_MODE_NORMAL
                        && hazard;
                end
            end
            PIU_ST_ENTRY: begin
                // Swap flags unless skip_swap is set, push PC, inhibit maskables, clear latch
                unique case (s_r.mode)
                    PIU_MODE_IRQ: s_nxt.flg_irq = core_i.flags_out;
                    PIU_MODE_NMI: s_nxt.flg_nmi = core_i.flags_out;
                    default: s_nxt.flg_normal = core_i.flags_out;
                endcase
                if (s_r.src_sel == 3'h0) begin
                    s_nxt.flags_in = s_r.flg_nmi;
                    s_nxt.mode = PIU_MODE_NMI;
                    s_nxt.nmi_latch = !nmi_b;
                end else begin
                    if (!s_r.skip_swap) begin
                        s_nxt.flags_in = s_r.flg_irq;
                    end
                    s_nxt.mode = PIU_MODE_IRQ;
                    if (s_r.src_sel == 3'h1) begin
                        s_nxt.src1_latch = 1'b0;
                    end
                    if (s_r.src_sel == 3'h2) begin
                        s_nxt.src2_latch = 1'b0;
                    end
                end
                s_nxt.prev2_mode = s_r.prev_mode;
                s_nxt.prev_mode = s_r.mode;
                s_nxt.stack_data = core_i.pc;
                s_nxt.stack_push = 1'b1;
                s_nxt.inhibit = 1'b1;
                s_nxt.entry_pulse = 1'b1;
                s_nxt.state = PIU_ST_VECTOR;
            end
            PIU_ST_VECTOR: begin
                unique case (s_r.src_sel)
                    3'h0: s_nxt.pc_load = `PIU_VEC_NMI;
                    3'h1: s_nxt.pc_load = `PIU_VEC_SRC1;
                    3'h2: s_nxt.pc_load = `PIU_VEC_SRC2;
                    3'h3: s_nxt.pc_load = `PIU_VEC_SRC3;
                    default: s_nxt.pc_load = `PIU_VEC_SRC4;
                endcase
                s_nxt.pc_load_en = 1'b1;
                s_nxt.state = PIU_ST_RUN;
            end
            default: s_nxt.state = PIU_ST_RUN;
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
            s_r.option <= `PIU_OPTION_RST;
            s_r.src1_prev <= 1'b1;
            s_r.src2_prev <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_dat_o = s_r.dat;
    assign wb_ack_o = s_r.ack;
    assign pc_load = s_r.pc_load;
    assign pc_load_en = s_r.pc_load_en;
    assign stack_data = s_r.stack_data;
    assign stack_push = s_r.stack_push;
    assign stack_pop = s_r.stack_pop;
    assign flags_in = s_r.flags_in;
    assign mode = s_r.mode;
    assign wake = s_r.wake;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    vector_after_push_a: assert property (stack_push |=> pc_load_en) else $error("no vector after push");
    nmi_vector_a: assert property (
        pc_load_en && mode == PIU_MODE_NMI |-> pc_load == `PIU_VEC_NMI) else $error("wrong nmi vector");
    no_mask_nest_a: assert property (
        s_r.state == PIU_ST_ENTRY && s_r.src_sel != 3'h0 |-> $past(s_r.mode) == PIU_MODE_NORMAL)
        else $error("maskable nested");
    gen_blocks_a: assert property (
        s_r.state == PIU_ST_RUN && core_i.insn_end && !gen && !hazard && !s_r.nmi_latch && !core_i.return_from_interrupt
        |=> s_r.state == PIU_ST_RUN) else $error("entry with enable clear");
    prio_one_a: assert property (
        s_r.state == PIU_ST_RUN && core_i.insn_end && !core_i.return_from_interrupt && !s_r.nmi_latch
        && any_mask && !s_r.inhibit && req1 |=> s_r.src_sel == 3'h1) else $error("priority wrong");
    nmi_clear_a: assert property (
        s_r.state == PIU_ST_ENTRY && s_r.src_sel == 3'h0 && nmi_b |=> !s_r.nmi_latch) else $error("nmi latch kept");
    latch_clear_a: assert property (
        s_r.state == PIU_ST_ENTRY && s_r.src_sel == 3'h2 |=> !s_r.src2_latch) else $error("edge latch kept");
    hazard_swap_a: assert property (
        s_r.state == PIU_ST_ENTRY && s_r.skip_swap && s_r.src_sel != 3'h0
        |=> mode == PIU_MODE_IRQ && $stable(flags_in)) else $error("flag pair swapped in hazard");
    option_write_a: assert property (
        wr_hit && wb_adr_i == `PIU_ADR_OPTION |=> s_r.option == $past(wb_dat_i[7:0])) else $error("option not stored");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    pop_on_return_from_interrupt_a: assert property (stack_pop |-> $past(core_i.return_from_interrupt)) else $error("spurious pop");

    nmi_entry_c: cover property (pc_load_en && mode == PIU_MODE_NMI);
    irq_entry_c: cover property (pc_load_en && pc_load == `PIU_VEC_SRC4);
    hazard_c: cover property (s_r.state == PIU_ST_ENTRY && s_r.skip_swap);
    return_from_interrupt_c: cover property (stack_pop ##1 mode == PIU_MODE_NORMAL);
endmodule

//--- piu_params.svh
/*
 * Constants of the prioritized interrupt unit: register map, option bit positions,
 * vector addresses and timing counts.
 * Assumes inclusion by bare name from the package.
 */
`ifndef PIU_PARAMS_SVH
`define PIU_PARAMS_SVH

// ****************************************
// Register map (byte addresses on the bus)
// ****************************************
`define PIU_ADR_OPTION 8'hC8
`define PIU_ADR_EVENTS 8'hCC
`define PIU_ADR_STATUS 8'hD0
`define PIU_OPTION_RST 8'h00

// ****************************************
// Option bit positions
// ****************************************
`define PIU_BIT_LES 6
`define PIU_BIT_ESB 5
`define PIU_BIT_GEN 4

// ****************************************
// Vector addresses, low byte of each pair
// ****************************************
`define PIU_VEC_NMI 12'hFFC
`define PIU_VEC_SRC1 12'hFF6
`define PIU_VEC_SRC2 12'hFF4
`define PIU_VEC_SRC3 12'hFF2
`define PIU_VEC_SRC4 12'hFF0

// ****************************************
// Timing: option write lasts 4 core cycles of 16 ns
// ****************************************
`define PIU_CORE_CYC_NS 16
`define PIU_CLK_NS 4
`define PIU_LDI_CYCLES 4
`define PIU_LDI_HAZARD 3

`endif

//--- piu_pkg.sv
/*
 * Types of the prioritized interrupt unit.
 * Assumes piu_params.svh is on the include path.
 */
package piu_pkg;
    `include "piu_params.svh"

    typedef enum logic [1:0] {
        PIU_MODE_NORMAL = 2'b00,
        PIU_MODE_IRQ = 2'b01,
        PIU_MODE_NMI = 2'b11
    } piu_mode_e;

    typedef enum logic [1:0] {
        PIU_ST_RUN = 2'b00,
        PIU_ST_ENTRY = 2'b01,
        PIU_ST_VECTOR = 2'b11
    } piu_state_e;

    // Carry and zero flag pair
    typedef struct packed {
        logic carry;
        logic zero;
    } piu_flags_s;

    // Core handshake toward the unit
    typedef struct packed {
        logic insn_end;
        logic return_from_interrupt;
        logic [11:0] pc;
        logic sleeping;
        piu_flags_s flags_out;
    } piu_core_req_s;

    typedef struct packed {
        logic [7:0] option;
        logic [3:0] events;
        logic nmi_latch;
        logic src1_latch;
        logic src2_latch;
        logic src1_prev;
        logic src2_prev;
        piu_mode_e mode;
        piu_mode_e prev_mode;
        piu_mode_e prev2_mode;
        piu_state_e state;
        logic [2:0] src_sel;
        logic skip_swap;
        logic [4:0] wr_cnt;
        piu_flags_s flg_normal;
        piu_flags_s flg_irq;
        piu_flags_s flg_nmi;
        piu_flags_s flags_in;
        logic [11:0] pc_load;
        logic pc_load_en;
        logic [11:0] stack_data;
        logic stack_push;
        logic stack_pop;
        logic inhibit;
        logic wake;
        logic entry_pulse;
        logic ack;
        logic [31:0] dat;
    } piu_state_s;
endpackage

//--- piu_core_model.sv
/*
 * Core model for the interrupt unit: an instruction boundary every fourth cycle,
 * jumps on vector loads, return pulses on request from the bench.
 * Assumes one clock shared with the unit and the bench driving its requests.
 */
`timescale 1ns/1ps
module piu_core_model
    import piu_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Bench requests
    input wire logic return_from_interrupt_req,
    input wire logic sleep_req,
    // Unit side
    input wire logic [11:0] pc_load,
    input wire logic pc_load_en,
    input wire piu_flags_s flags_in,
    output piu_core_req_s core_o
);
    // ****************
    // Sequencer
    // ****************
    logic [1:0] cnt_r;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 2'h0;
            core_o <= '0;
        end else begin
            cnt_r <= cnt_r + 2'h1;
            // A sleeping core reaches no boundary until the bench drops sleep_req
            core_o.insn_end <= (cnt_r == 2'h2) && !sleep_req;
            core_o.return_from_interrupt <= return_from_interrupt_req;
            core_o.sleeping <= sleep_req;
            core_o.flags_out <= flags_in;
            if (pc_load_en) begin
                core_o.pc <= pc_load;
            end else if (core_o.insn_end) begin
                core_o.pc <= core_o.pc + 12'h001;
            end
        end
    end
endmodule

//--- tb_prioritized_interrupt_unit.sv
/*
 * Self-checking bench of the prioritized interrupt unit.
 * Assumes piu_pkg, piu_unit and piu_core_model are compiled first.
 */
`timescale 1ns/1ps
module tb_prioritized_interrupt_unit;
    import piu_pkg::*;
    // ****************
    // Signals
    // ****************
    logic sys_clk, rst_b, cyc, we, ack, nmi_b, src1_b, src2, src3_b, src4_b;
    logic return_from_interrupt_req, sleep_req, pc_load_en, push, pop, wake;
    logic [7:0] adr;
    logic [3:0] sel, ev;
    logic [31:0] wdat, rdat, q;
    logic [11:0] pc_load, sdat;
    piu_flags_s flags;
    piu_mode_e mode;
    piu_core_req_s core;
    int n_fail = 0;
    int cmp_count = 0;
    wire [3:0] seen_w = {core.insn_end, pc_load_en, pop, push};

    piu_unit piu_unit_i (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .nmi_b(nmi_b), .src1_b(src1_b), .src2(src2), .src3_b(src3_b),
        .src4_b(src4_b), .event_in(ev), .core_i(core), .pc_load(pc_load),
        .pc_load_en(pc_load_en), .stack_data(sdat), .stack_push(push), .stack_pop(pop),
        .flags_in(flags), .mode(mode), .wake(wake));
    piu_core_model piu_core_model_i (.sys_clk(sys_clk), .rst_b(rst_b), .return_from_interrupt_req(return_from_interrupt_req),
        .sleep_req(sleep_req), .pc_load(pc_load), .pc_load_en(pc_load_en),
        .flags_in(flags), .core_o(core));

    // ****************
    // Shared tasks
    // ****************
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic hang(input string what);
        n_fail++;
        $display("MISMATCH %s expected answer seen none", what);
        summarize();
    endtask
    // Outputs are read at the edge, so the value seen is that of the cycle before
    task automatic await(input int k);
        int i;
        for (i = 0; i < 200; i++) begin
            @(posedge sys_clk);
            if (seen_w[k] === 1'b1) break;
        end
        if (i == 200) hang("handshake");
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (i = 0; i < 50; i++) begin
            @(posedge sys_clk);
            if (ack === 1'b1) break;
        end
        if (i == 50) hang("bus ack");
        q = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic opt(input logic [31:0] v);
        wb(1'b1, 8'hC8, v);
    endtask
    task automatic entry(input logic [11:0] vec, input piu_mode_e m);
        await(0);
        chk("entry mode", mode, m);
        chk("pushed pc", sdat, core.pc);
        await(2);
        chk("vector", pc_load, vec);
    endtask
    task automatic leave(input piu_mode_e m);
        @(posedge sys_clk);
        return_from_interrupt_req <= 1'b1;
        @(posedge sys_clk);
        return_from_interrupt_req <= 1'b0;
        await(1);
        chk("mode after return", mode, m);
    endtask
    task automatic quiet(input int n);
        int c;
        c = 0;
        repeat (n) begin
            @(posedge sys_clk);
            if (push === 1'b1) c++;
        end
        chk("spurious entries", c, 0);
    endtask
    task automatic blip(input int k);
        @(posedge sys_clk);
        case (k)
            0: nmi_b <= 1'b0;
            1: src1_b <= 1'b0;
            default: src2 <= ~src2;
        endcase
        @(posedge sys_clk);
        case (k)
            0: nmi_b <= 1'b1;
            1: src1_b <= 1'b1;
            default: src2 <= ~src2;
        endcase
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        chk("reset mode", mode, PIU_MODE_NORMAL);
        chk("reset flags", flags, 32'h0);
        wb(1'b0, 8'hC8, 32'h0);
        chk("option read", q, 32'h0);
        opt(32'h10);
        wb(1'b0, 8'hC8, 32'h0);
        chk("option write-only", q, 32'h0);
        wb(1'b0, 8'hD0, 32'h0);
        chk("status", q, 32'h0);
        wb(1'b0, 8'hF0, 32'h0);
        chk("unmapped", q, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_level();
        src3_b <= 1'b0;
        entry(12'hFF2, PIU_MODE_IRQ);
        src3_b <= 1'b1;
        leave(PIU_MODE_NORMAL);
        src4_b <= 1'b0;
        entry(12'hFF0, PIU_MODE_IRQ);
        src4_b <= 1'b1;
        leave(PIU_MODE_NORMAL);
        // A low level gone before the next boundary is forgotten
        await(3);
        src3_b <= 1'b0;
        @(posedge sys_clk);
        src3_b <= 1'b1;
        quiet(30);
        $display("test level done");
    endtask
    task automatic t_prio();
        opt(32'h50);
        src1_b <= 1'b0;
        src3_b <= 1'b0;
        src4_b <= 1'b0;
        entry(12'hFF6, PIU_MODE_IRQ);
        quiet(40);
        blip(0);
        entry(12'hFFC, PIU_MODE_NMI);
        leave(PIU_MODE_IRQ);
        quiet(20);
        src1_b <= 1'b1;
        leave(PIU_MODE_NORMAL);
        entry(12'hFF2, PIU_MODE_IRQ);
        src3_b <= 1'b1;
        leave(PIU_MODE_NORMAL);
        entry(12'hFF0, PIU_MODE_IRQ);
        src4_b <= 1'b1;
        leave(PIU_MODE_NORMAL);
        $display("test priority done");
    endtask
    task automatic t_edge();
        opt(32'h10);
        blip(1);
        entry(12'hFF6, PIU_MODE_IRQ);
        leave(PIU_MODE_NORMAL);
        quiet(30);
        opt(32'h30);
        blip(2);
        entry(12'hFF4, PIU_MODE_IRQ);
        blip(2);
        blip(2);
        leave(PIU_MODE_NORMAL);
        entry(12'hFF4, PIU_MODE_IRQ);
        leave(PIU_MODE_NORMAL);
        quiet(30);
        opt(32'h10);
        src2 <= 1'b0;
        entry(12'hFF4, PIU_MODE_IRQ);
        leave(PIU_MODE_NORMAL);
        src2 <= 1'b1;
        quiet(30);
        $display("test edge done");
    endtask
    task automatic t_gen();
        // Clearing enable from set leaves a short window in which a request still enters
        opt(32'h0);
        src3_b <= 1'b0;
        entry(12'hFF2, PIU_MODE_IRQ);
        src3_b <= 1'b1;
        leave(PIU_MODE_NORMAL);
        opt(32'h0);
        src3_b <= 1'b0;
        quiet(30);
        sleep_req <= 1'b1;
        blip(0);
        repeat (10) @(posedge sys_clk);
        chk("wake without enable", wake, 1'b0);
        sleep_req <= 1'b0;
        entry(12'hFFC, PIU_MODE_NMI);
        leave(PIU_MODE_NORMAL);
        quiet(30);
        sleep_req <= 1'b1;
        opt(32'h10);
        repeat (4) @(posedge sys_clk);
        chk("wake with enable", wake, 1'b1);
        sleep_req <= 1'b0;
        entry(12'hFF2, PIU_MODE_IRQ);
        src3_b <= 1'b1;
        leave(PIU_MODE_NORMAL);
        $display("test enable done");
    endtask
    task automatic t_events();
        @(posedge sys_clk);
        ev <= 4'h5;
        @(posedge sys_clk);
        ev <= 4'h0;
        wb(1'b0, 8'hCC, 32'h0);
        chk("event flags", q, 32'h5);
        wb(1'b1, 8'hCC, 32'h1);
        wb(1'b0, 8'hCC, 32'h0);
        chk("event clear", q, 32'h4);
        $display("test events done");
    endtask

    // ****************
    // Clock, reset and sequence
    // ****************
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        {rst_b, cyc, we, return_from_interrupt_req, sleep_req} = '0;
        // Source two idles high, matching the edge history that reset leaves
        {nmi_b, src1_b, src2, src3_b, src4_b} = 5'h1F;
        adr = 8'h00;
        sel = 4'h1;
        ev = 4'h0;
        wdat = 32'h0;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset();
        t_level();
        t_prio();
        t_edge();
        t_gen();
        t_events();
        summarize();
    end
endmodule
